// *** rtl/status_light_flash_coder.v ***
// status lamp controller: power, scan and diagnostic lamps with apb registers
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "status_light_map.vh"

module status_light_flash_coder #(
    parameter TICK_CYC   = `SL_CLK_KHZ,
    parameter ON_T       = `SL_FLASH_ON_MS,
    parameter OFF_T      = `SL_FLASH_OFF_MS,
    parameter SHORT_T    = `SL_SHORT_MS,
    parameter LONG_T     = `SL_LONG_MS,
    parameter PULSE_T    = `SL_PULSE_MS,
    parameter SCAN_LIM_T = `SL_SCAN_LIMIT_MS
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        supply_good,
    input  wire        battery_low,
    input  wire        scan_running,
    input  wire        scan_start,
    output reg         power_lamp,
    output reg         scan_lamp,
    output reg  [7:0]  diag_level,
    output reg         outputs_enable,
    output reg         analog_zero,
    output wire        irq
);
    // ------------------------------------------------------------------
    // pin synchronisers: three stages, change counted when 2 and 3 agree
    // ------------------------------------------------------------------
    reg  [3:0] s1_reg, s2_reg, s3_reg, pin_reg;
    wire [3:0] pins = {scan_start, scan_running, battery_low, supply_good};

    always @(posedge mclk) begin
        if (rst) begin
            s1_reg  <= 4'h0;
            s2_reg  <= 4'h0;
            s3_reg  <= 4'h0;
            pin_reg <= 4'h0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
        end
    end

    wire sup_ok   = pin_reg[0];
    wire batt_low = pin_reg[1];
    wire running  = pin_reg[2];
    wire start_lv = pin_reg[3];
    reg  start_d_reg;

    // ------------------------------------------------------------------
    // millisecond tick from the 40 MHz clock
    // ------------------------------------------------------------------
    reg [15:0] div_reg;
    reg        tick;

    always @(posedge mclk) begin
        if (rst) begin
            div_reg <= 16'h0000;
            tick    <= 1'b0;
        end else if (div_reg >= TICK_CYC[15:0] - 16'h0001) begin
            div_reg <= 16'h0000;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 16'h0001;
            tick    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------------
    reg  [`SL_CTRL_W-1:0] ctrl_reg;
    reg  [`SL_FLT_W-1:0]  flt_reg;
    reg  [`SL_EVT_W-1:0]  ist_reg, imask_reg;
    reg  [7:0]            slot_reg;
    reg                   st_done_reg, st_fail_reg;
    reg                   scan_long_reg;
    wire                  wr = psel & penable & pwrite;
    wire [`SL_FLT_W-1:0]  faults = flt_reg | {{(`SL_FLT_W-1){1'b0}}, scan_long_reg};
    wire [`SL_EVT_W-1:0]  evt;
    reg  [`SL_FLT_W-1:0]  faults_d_reg;
    reg                   batt_d_reg;

    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign evt     = {batt_low & ~batt_d_reg, faults & ~faults_d_reg};
    assign irq     = |(ist_reg & imask_reg);

    // writes; set of a status bit beats a simultaneous write-one clear
    always @(posedge mclk) begin
        if (rst) begin
            ctrl_reg     <= {`SL_CTRL_W{1'b0}};
            flt_reg      <= {`SL_FLT_W{1'b0}};
            ist_reg      <= {`SL_EVT_W{1'b0}};
            imask_reg    <= {`SL_EVT_W{1'b0}};
            slot_reg     <= 8'h00;
            faults_d_reg <= {`SL_FLT_W{1'b0}};
            batt_d_reg   <= 1'b0;
        end else begin
            faults_d_reg <= faults;
            batt_d_reg   <= batt_low;
            if (wr && hit(paddr, `SL_CTRL_OFS))
                ctrl_reg <= pwdata[`SL_CTRL_W-1:0];
            if (wr && hit(paddr, `SL_FLT_OFS))
                flt_reg <= pwdata[`SL_FLT_W-1:0];
            if (wr && hit(paddr, `SL_IRQ_MASK_OFS))
                imask_reg <= pwdata[`SL_EVT_W-1:0];
            if (wr && hit(paddr, `SL_SLOT_OFS))
                slot_reg <= pwdata[7:0];
            if (wr && hit(paddr, `SL_IRQ_STAT_OFS))
                ist_reg <= (ist_reg & ~pwdata[`SL_EVT_W-1:0]) | evt;
            else
                ist_reg <= ist_reg | evt;
        end
    end

    // read mux, unmapped reads give zero
    always @* begin
        prdata = 32'h0000_0000;
        if (hit(paddr, `SL_CTRL_OFS))
            prdata[`SL_CTRL_W-1:0] = ctrl_reg;
        else if (hit(paddr, `SL_FLT_OFS))
            prdata[`SL_FLT_W-1:0] = faults;
        else if (hit(paddr, `SL_STAT_OFS))
            prdata[5:0] = {st_fail_reg, st_done_reg, batt_low, running,
                           sup_ok, scan_lamp};
        else if (hit(paddr, `SL_IRQ_STAT_OFS))
            prdata[`SL_EVT_W-1:0] = ist_reg;
        else if (hit(paddr, `SL_IRQ_MASK_OFS))
            prdata[`SL_EVT_W-1:0] = imask_reg;
        else if (hit(paddr, `SL_SLOT_OFS))
            prdata[7:0] = slot_reg;
    end

    // ------------------------------------------------------------------
    // power-up self-test result, latched once after reset only
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            st_done_reg <= 1'b0;
            st_fail_reg <= 1'b0;
        end else if (!st_done_reg && ctrl_reg[`SL_CTRL_ST_DONE]) begin
            st_done_reg <= 1'b1;
            st_fail_reg <= ctrl_reg[`SL_CTRL_ST_FAIL];
        end
    end

    // ------------------------------------------------------------------
    // scan watchdog: a scan longer than the limit is a lost scan
    // ------------------------------------------------------------------
    reg [15:0] scan_ms_reg;

    always @(posedge mclk) begin
        if (rst) begin
            scan_ms_reg   <= 16'h0000;
            scan_long_reg <= 1'b0;
            start_d_reg   <= 1'b0;
        end else begin
            start_d_reg <= start_lv;
            if (wr && hit(paddr, `SL_FLT_OFS) && !pwdata[`SL_F_SCAN_LONG]) // set wins
                scan_long_reg <= 1'b0;
            if (!running) begin
                scan_ms_reg <= 16'h0000;
            end else if (start_lv && !start_d_reg) begin
                scan_ms_reg <= 16'h0000;
            end else if (tick) begin
                if (scan_ms_reg >= SCAN_LIM_T[15:0])
                    scan_long_reg <= 1'b1;
                else
                    scan_ms_reg <= scan_ms_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // code selection, highest listed fault first
    // ------------------------------------------------------------------
    reg  [3:0] cd0, cd1, cd2;
    reg        code_on;
    wire       digital = ctrl_reg[`SL_CTRL_DIGITAL];

    // zero digit flashes ten times
    function [3:0] ten0;
        input [3:0] v;
        begin
            ten0 = (v == 4'h0) ? 4'hA : v;
        end
    endfunction

    always @* begin
        cd0 = 4'h0;
        cd1 = 4'h0;
        cd2 = 4'h0;
        code_on = 1'b1;
        if (faults[`SL_F_SCAN_LONG]) begin
            cd0 = 4'h1; cd1 = 4'h2; cd2 = 4'h3;
        end else if (faults[`SL_F_OVERHEAD]) begin
            cd0 = 4'h1; cd1 = 4'h2; cd2 = 4'h4;
        end else if (faults[`SL_F_MEMORY]) begin
            cd0 = 4'h1; cd1 = 4'h2; cd2 = 4'h5;
        end else if (faults[`SL_F_DRIVER]) begin
            cd0 = 4'h2; cd1 = 4'h2; cd2 = 4'h2;
        end else if (faults[`SL_F_SLOT]) begin
            cd0 = 4'h2; cd1 = 4'h2; cd2 = ten0(slot_reg[3:0]);
        end else if (faults[`SL_F_BLOCK]) begin
            cd0 = 4'h3;
            cd1 = ten0({1'b0, slot_reg[6:4]});
            cd2 = ten0(slot_reg[3:0]);
        end else if (digital && batt_low) begin
            cd0 = 4'h6; cd1 = 4'h2; cd2 = 4'h1;
        end else begin
            code_on = 1'b0;
        end
    end

    wire code_lamp;

    flash_digit_seq #(
        .ON_T    (ON_T),
        .OFF_T   (OFF_T),
        .SHORT_T (SHORT_T),
        .LONG_T  (LONG_T)
    ) u_seq (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick),
        .run  (code_on & running),
        .d0   (cd0),
        .d1   (cd1),
        .d2   (cd2),
        .lamp (code_lamp)
    );

    // ------------------------------------------------------------------
    // pulse ramp for software-class faults
    // ------------------------------------------------------------------
    reg [15:0] ramp_reg;
    reg        ramp_up_reg;
    reg        blink_reg;

    always @(posedge mclk) begin
        if (rst) begin
            ramp_reg    <= 16'h0000;
            ramp_up_reg <= 1'b1;
            blink_reg   <= 1'b0;
        end else if (tick) begin
            if (ramp_reg >= PULSE_T[15:0] - 16'h0001) begin
                ramp_reg    <= 16'h0000;
                ramp_up_reg <= ~ramp_up_reg;
                blink_reg   <= ~blink_reg;
            end else begin
                ramp_reg <= ramp_reg + 16'h0001;
            end
        end
    end

    wire [7:0] ramp_lvl = ramp_reg[9:2];

    // ------------------------------------------------------------------
    // lamp and output drivers
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            power_lamp     <= 1'b0;
            scan_lamp      <= 1'b0;
            diag_level     <= 8'h00;
            outputs_enable <= 1'b0;
            analog_zero    <= 1'b1;
        end else begin
            // battery flash only on analog and ring variants
            if (!sup_ok)
                power_lamp <= 1'b0;
            else if (batt_low && !digital)
                power_lamp <= blink_reg;
            else
                power_lamp <= 1'b1;
            scan_lamp      <= running & sup_ok;
            outputs_enable <= running & sup_ok;
            analog_zero    <= ~(running & sup_ok);
            if (!st_done_reg || st_fail_reg)
                diag_level <= 8'hFF;
            else if (!running)
                diag_level <= 8'h00;
            else if (faults[`SL_F_SOFT])
                diag_level <= ramp_up_reg ? ramp_lvl : ~ramp_lvl;
            else
                diag_level <= code_lamp ? 8'hFF : 8'h00;
        end
    end
endmodule // status_light_flash_coder

// *** rtl/status_light_map.vh ***
// constants for the status lamp flash coder: apb map, field positions, timings
`ifndef STATUS_LIGHT_MAP_VH
`define STATUS_LIGHT_MAP_VH

// register byte offsets
`define SL_CTRL_OFS        12'h000
`define SL_FLT_OFS         12'h004
`define SL_STAT_OFS        12'h008
`define SL_IRQ_STAT_OFS    12'h00C
`define SL_IRQ_MASK_OFS    12'h010
`define SL_SLOT_OFS        12'h014
`define SL_ADDR_W          12

// control fields
`define SL_CTRL_DIGITAL    0
`define SL_CTRL_ST_DONE    1
`define SL_CTRL_ST_FAIL    2
`define SL_CTRL_W          3

// fault register fields
`define SL_F_SCAN_LONG     0
`define SL_F_OVERHEAD      1
`define SL_F_MEMORY        2
`define SL_F_DRIVER        3
`define SL_F_SLOT          4
`define SL_F_BLOCK         5
`define SL_F_SOFT          6
`define SL_FLT_W           7
`define SL_EVT_W           8
`define SL_EVT_BATT        7

// timings in milliseconds, clock in kHz
`define SL_FLASH_ON_MS     200
`define SL_FLASH_OFF_MS    200
`define SL_SHORT_MS        800
`define SL_LONG_MS         2000
`define SL_PULSE_MS        1000
`define SL_SCAN_LIMIT_MS   200
`define SL_CLK_KHZ         40000

`endif

// *** rtl/flash_digit_seq.v ***
// flash sequencer: long pause, three digit flash groups, long pause, repeat
`timescale 1ns/1ps
`include "status_light_map.vh"

module flash_digit_seq #(
    parameter TICK_MS  = 1,
    parameter ON_T     = `SL_FLASH_ON_MS,
    parameter OFF_T    = `SL_FLASH_OFF_MS,
    parameter SHORT_T  = `SL_SHORT_MS,
    parameter LONG_T   = `SL_LONG_MS
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        tick,
    input  wire        run,
    input  wire [3:0]  d0,
    input  wire [3:0]  d1,
    input  wire [3:0]  d2,
    output reg         lamp
);
    localparam S_IDLE = 4'b0001;
    localparam S_LONG = 4'b0010;
    localparam S_ON   = 4'b0100;
    localparam S_GAP  = 4'b1000;

    reg [3:0]  state_reg;
    reg [15:0] tmr_reg;
    reg [3:0]  cnt_reg;
    reg [1:0]  dig_reg;
    reg [3:0]  cur;

    // digits latched at every long pause so a code never tears mid-group
    reg [3:0]  c0_reg, c1_reg, c2_reg;

    always @* begin
        case (dig_reg)
            2'h0:    cur = c0_reg;
            2'h1:    cur = c1_reg;
            default: cur = c2_reg;
        endcase
    end

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst || !run) begin
            state_reg <= S_IDLE;
            tmr_reg   <= 16'h0000;
            cnt_reg   <= 4'h0;
            dig_reg   <= 2'h0;
            lamp      <= 1'b0;
            c0_reg    <= 4'h0;
            c1_reg    <= 4'h0;
            c2_reg    <= 4'h0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    state_reg <= S_LONG;
                    tmr_reg   <= 16'h0000;
                end
                S_LONG: if (tick) begin
                    if (tmr_reg >= LONG_T[15:0] - 16'h0001) begin
                        state_reg <= S_ON;
                        tmr_reg   <= 16'h0000;
                        dig_reg   <= 2'h0;
                        cnt_reg   <= 4'h0;
                        c0_reg    <= d0;
                        c1_reg    <= d1;
                        c2_reg    <= d2;
                        lamp      <= 1'b1;
                    end else begin
                        tmr_reg <= tmr_reg + 16'h0001;
                    end
                end
                S_ON: if (tick) begin
                    if (tmr_reg >= ON_T[15:0] - 16'h0001) begin
                        lamp      <= 1'b0;
                        state_reg <= S_GAP;
                        tmr_reg   <= 16'h0000;
                        cnt_reg   <= cnt_reg + 4'h1;
                    end else begin
                        tmr_reg <= tmr_reg + 16'h0001;
                    end
                end
                S_GAP: if (tick) begin
                    // within a digit the off time, between digits the short pause
                    if (cnt_reg < cur) begin
                        if (tmr_reg >= OFF_T[15:0] - 16'h0001) begin
                            state_reg <= S_ON;
                            tmr_reg   <= 16'h0000;
                            lamp      <= 1'b1;
                        end else begin
                            tmr_reg <= tmr_reg + 16'h0001;
                        end
                    end else if (dig_reg == 2'h2) begin
                        state_reg <= S_LONG;
                        tmr_reg   <= 16'h0000;
                    end else if (tmr_reg >= SHORT_T[15:0] - 16'h0001) begin
                        dig_reg   <= dig_reg + 2'h1;
                        cnt_reg   <= 4'h0;
                        state_reg <= S_ON;
                        tmr_reg   <= 16'h0000;
                        lamp      <= 1'b1;
                    end else begin
                        tmr_reg <= tmr_reg + 16'h0001;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // flash_digit_seq

// *** tb/status_light_assertions.sv ***
// checker: lamp, self-test and register bus assertions for the lamp coder
`timescale 1ns/1ps
module status_light_checks (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        supply_good,
    input wire logic        battery_low,
    input wire logic        scan_running,
    input wire logic        scan_start,
    input wire logic        power_lamp,
    input wire logic        scan_lamp,
    input wire logic [7:0]  diag_level,
    input wire logic        outputs_enable,
    input wire logic        analog_zero,
    input wire logic        irq
);
// ----
// shadows of what software wrote
// ----
logic       st_seen;
logic       st_fail;
logic       dig_sh;
logic [7:0] mask_sh;
wire        wr = psel && penable && pwrite;

// self-test result latches once per reset, like the design
always @(posedge mclk) begin
    if (rst) begin
        st_seen <= 1'h0;
        st_fail <= 1'h0;
        dig_sh  <= 1'h0;
        mask_sh <= 8'h00;
    end else if (wr && paddr == 12'h000) begin
        dig_sh <= pwdata[0];
        if (!st_seen && pwdata[1]) begin
            st_seen <= 1'h1;
            st_fail <= pwdata[2];
        end
    end else if (wr && paddr == 12'h010) begin
        mask_sh <= pwdata[7:0];
    end
end

// ----
// properties
// ----
default clocking @(posedge mclk); endclocking
default disable iff (rst);

// three samples so a lamp that lags the latch or scan stop is not blamed
sequence quiet_pass;
    st_seen && !st_fail && !scan_lamp ##1 !scan_lamp ##1 !scan_lamp;
endsequence

AST_SELFTEST_ON: assert property ($fell(rst) |=> (diag_level == 8'hFF)[*2])
    else $error("diag lamp not lit after reset");
AST_ST_FAIL: assert property (st_seen && st_fail |=> diag_level == 8'hFF)
    else $error("failed self-test lamp not steady");
AST_ST_PASS: assert property (quiet_pass |-> diag_level == 8'h00)
    else $error("diag lamp lit after passed self-test");
AST_POWER_OFF: assert property ((!supply_good)[*8] |-> !power_lamp)
    else $error("power lamp lit on bad supply");
AST_POWER_ON: assert property ((supply_good && (!battery_low || dig_sh))[*8] |-> power_lamp)
    else $error("power lamp not steady");
AST_SCAN_ON: assert property ((scan_running && supply_good)[*8] |-> scan_lamp && outputs_enable)
    else $error("scan lamp dark while running");
AST_SCAN_OFF: assert property ((!scan_running)[*8] |-> !scan_lamp)
    else $error("scan lamp lit while stopped");
AST_FORCE: assert property (!scan_lamp |-> !outputs_enable && analog_zero)
    else $error("outputs live with scan lamp dark");
AST_IRQ_MASK: assert property (mask_sh == 8'h00 |-> !irq)
    else $error("irq with all sources masked");
AST_UNMAPPED: assert property (psel && penable && !pwrite && paddr == 12'h0FC |-> prdata == 32'h0)
    else $error("unmapped read not zero");
AST_READY: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus access stalled or errored");
endmodule // status_light_checks

bind status_light_flash_coder status_light_checks u_status_light_checks (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_good(supply_good), .battery_low(battery_low),
    .scan_running(scan_running), .scan_start(scan_start), .power_lamp(power_lamp),
    .scan_lamp(scan_lamp), .diag_level(diag_level), .outputs_enable(outputs_enable),
    .analog_zero(analog_zero), .irq(irq)
);

// *** tb/lamp_panel_model.sv ***
// lamp panel model: watches the diagnostic lamp and decodes flash codes
`timescale 1ns/1ps
module lamp_panel_model #(
    parameter DIGIT_GAP = 12,
    parameter CODE_GAP  = 30
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  diag_level,
    output logic      [11:0] code,
    output logic      [7:0]  code_count
);
logic [7:0]  dk;
logic [3:0]  fc;
logic [1:0]  di;
logic [11:0] tmp;
logic        lit_q;
wire         lit = diag_level[7];

// counts flashes; a short dark ends a digit, a long dark ends the code
always @(posedge mclk) begin
    lit_q <= lit;
    if (rst) begin
        dk         <= 8'h00;
        fc         <= 4'h0;
        di         <= 2'h0;
        code       <= 12'h000;
        code_count <= 8'h00;
    end else if (lit) begin
        dk <= 8'h00;
        if (!lit_q) fc <= fc + 4'h1;
    end else begin
        if (dk != 8'hFF) dk <= dk + 8'h01;
        if (dk == DIGIT_GAP && fc != 4'h0) begin
            tmp <= {tmp[7:0], fc};
            di  <= di + 2'h1;
            fc  <= 4'h0;
        end
        // only a full three-digit group counts as a code
        if (dk == CODE_GAP) begin
            if (di == 2'h3) begin
                code       <= tmp;
                code_count <= code_count + 8'h01;
            end
            di <= 2'h0;
        end
    end
end
endmodule // lamp_panel_model

// *** tb/tb_status_light_flash_coder.sv ***
// testbench for the status lamp coder with a lamp panel model
`timescale 1ns/1ps
module tb_status_light_flash_coder;
logic        mclk, rst, psel, penable, pwrite, kick;
logic        supply_good, battery_low, scan_running, scan_start;
logic [11:0] paddr;
logic [31:0] pwdata, rd;
logic [2:0]  kc;
wire  [31:0] prdata;
wire         pready, pslverr, power_lamp, scan_lamp, outputs_enable, analog_zero, irq;
wire  [7:0]  diag_level, code_count;
wire  [11:0] code;
integer      errors, total_checks, cyc;

initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
end

// short ms tick keeps every flash a few cycles long; pulse and watchdog keep real spans
status_light_flash_coder #(.TICK_CYC(4), .ON_T(2), .OFF_T(2), .SHORT_T(4),
    .LONG_T(10)) u_status_light_flash_coder (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_good(supply_good), .battery_low(battery_low), .scan_running(scan_running),
    .scan_start(scan_start), .power_lamp(power_lamp), .scan_lamp(scan_lamp),
    .diag_level(diag_level), .outputs_enable(outputs_enable),
    .analog_zero(analog_zero), .irq(irq));

lamp_panel_model u_lamp_panel_model (
    .mclk(mclk), .rst(rst), .diag_level(diag_level), .code(code), .code_count(code_count));

// scan starts every 10 cycles, well inside the 800-cycle watchdog
always @(posedge mclk) begin
    kc <= (kc == 3'h4) ? 3'h0 : kc + 3'h1;
    if (kc == 3'h4) scan_start <= kick & ~scan_start;
end

// hang guard
always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
        errors = errors + 1;
        tally_and_finish;
    end
end

// ----
// helpers
// ----
task chk(input logic ok, input string m);
    begin
        total_checks++;
        if (ok !== 1'h1) begin
            errors++;
            $display("FAIL t=%0t %s", $time, m);
        end
    end
endtask

task cycles(input integer n);
    repeat (n) @(posedge mclk);
endtask

// one transfer; ends with an idle edge so calls may follow back to back
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1) @(posedge mclk);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    end
endtask

task wait_codes(input integer n);
    logic [7:0] c0;
    begin
        repeat (n) begin
            c0 = code_count;
            while (code_count === c0) @(posedge mclk);
        end
    end
endtask

task do_reset;
    begin
        rst <= 1'h1;
        cycles(5);
        rst <= 1'h0;
        @(posedge mclk);
    end
endtask

task tally_and_finish;
    begin
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    end
endtask

// ----
// scenarios
// ----
task t_selftest;
    begin
        cycles(2);
        chk(diag_level === 8'hFF, "diag dark in self-test");
        apb(1'h1, 12'h000, 32'h6);
        cycles(3);
        chk(diag_level === 8'hFF, "fail not held");
        do_reset;
        apb(1'h1, 12'h000, 32'h2);
        cycles(3);
        chk(diag_level === 8'h00, "pass not dark");
        apb(1'h1, 12'h000, 32'h6);
        cycles(3);
        chk(diag_level === 8'h00, "late failure lit diag");
        $display("test selftest done");
    end
endtask

task t_power;
    logic s0, s1;
    begin
        supply_good <= 1'h0;
        cycles(8);
        chk(power_lamp === 1'h0, "power lit on bad supply");
        supply_good <= 1'h1;
        cycles(8);
        chk(power_lamp === 1'h1, "power dark");
        battery_low <= 1'h1;
        s0 = 1'h0;
        s1 = 1'h0;
        repeat (8200) begin
            @(posedge mclk);
            if (power_lamp === 1'h0) s0 = 1'h1;
            if (power_lamp === 1'h1) s1 = 1'h1;
        end
        chk(s0 && s1, "power not flashing");
        battery_low <= 1'h0;
        cycles(40);
        $display("test power done");
    end
endtask

task t_scan(input logic on);
    begin
        scan_running <= on;
        kick <= on;
        cycles(10);
        chk(scan_lamp === on && outputs_enable === on && analog_zero === !on, "scan");
        $display("test scan done");
    end
endtask

// old sequence may be mid-way, so judge the second code and its repeat
task t_code(input logic [31:0] f, s, c, input logic [11:0] e);
    begin
        apb(1'h1, 12'h014, s);
        apb(1'h1, 12'h000, c);
        apb(1'h1, 12'h004, f);
        wait_codes(2);
        chk(code === e, "wrong code");
        wait_codes(1);
        chk(code === e, "code not repeated");
        $display("test code done");
    end
endtask

task t_soft;
    logic s;
    begin
        apb(1'h1, 12'h004, 32'h40);
        s = 1'h0;
        repeat (64) begin
            @(posedge mclk);
            if (diag_level !== 8'h00 && diag_level !== 8'hFF) s = 1'h1;
        end
        chk(s, "diag not pulsing");
        apb(1'h1, 12'h004, 32'h0);
        $display("test pulse done");
    end
endtask

task t_irq;
    begin
        apb(1'h1, 12'h010, 32'h1);
        apb(1'h1, 12'h00C, 32'hFF);
        kick <= 1'h0;
        cycles(900);
        chk(irq === 1'h1, "watchdog irq missing");
        apb(1'h0, 12'h004, 32'h0);
        chk(rd[0] === 1'h1, "watchdog bit clear");
        apb(1'h1, 12'h010, 32'h0);
        chk(irq === 1'h0, "masked irq high");
        kick <= 1'h1;
        cycles(20);
        apb(1'h1, 12'h004, 32'h0);
        apb(1'h1, 12'h00C, 32'h1);
        apb(1'h0, 12'h00C, 32'h0);
        chk(rd[0] === 1'h0, "status not cleared");
        apb(1'h1, 12'h010, 32'h1);
        chk(irq === 1'h0, "irq after clear");
        apb(1'h0, 12'h0FC, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        apb(1'h0, 12'h008, 32'h0);
        chk(rd[5:0] === 6'h17, "status read");
        $display("test irq done");
    end
endtask

initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
    {supply_good, battery_low, scan_running, scan_start, kick, kc} = {1'h1, 7'h0};
    {errors, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
    cycles(5);
    rst <= 1'h0;
    @(posedge mclk);
    t_selftest;
    t_power;
    t_scan(1'h1);
    t_code(32'h01, 32'h0, 32'h0, 12'h123);
    t_code(32'h02, 32'h0, 32'h0, 12'h124);
    t_code(32'h04, 32'h0, 32'h0, 12'h125);
    t_code(32'h08, 32'h0, 32'h0, 12'h222);
    t_code(32'h10, 32'h3, 32'h0, 12'h223);
    t_code(32'h20, 32'h30, 32'h0, 12'h33A);
    battery_low <= 1'h1;
    t_code(32'h0, 32'h0, 32'h1, 12'h621);
    battery_low <= 1'h0;
    t_soft;
    t_irq;
    t_scan(1'h0);
    tally_and_finish;
end
endmodule // tb_status_light_flash_coder
